// *** adc_result_format.sv ***
module adc_result_format (
   input  wire logic        mclk_in,
   input  wire logic        arst_n_in,
   input  wire logic [7:0]  sfr_addr_in,
   input  wire logic [7:0]  sfr_wdata_in,
   input  wire logic        sfr_wr_in,
   output logic      [7:0]  sfr_rdata_out,
   input  wire logic        conv_done_in,
   input  wire logic [11:0] sample_in,
   output logic             result_update_out,
   output logic      [11:0] gain_word_out,
   output logic             gain_extra_out
);

   // ---------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------
   logic rst_meta_q;
   logic rst_n_q;

   always_ff @(posedge mclk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   // ---------------------------------------------------------------
   // Register state
   // ---------------------------------------------------------------
   logic [7:0]  cfg_q;
   logic [7:0]  ctl_q;
   logic [15:0] result_q;
   logic [15:0] result_d;
   logic        update_q;
   logic [7:0]  gain_addr_q;
   logic [7:0]  gain_upper_q;
   logic [3:0]  gain_lower_q;
   logic        gain_extra_q;
   logic [7:0]  rdata_q;

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   wire               cfg_wr    = sfr_wr_in && sfr_addr_in == adc_fmt_pkg::CFG_ADDR;
   wire               ctl_wr    = sfr_wr_in && sfr_addr_in == adc_fmt_pkg::CTL_ADDR;
   wire               hi_wr     = sfr_wr_in && sfr_addr_in == adc_fmt_pkg::RES_HI_ADDR;
   wire               lo_wr     = sfr_wr_in && sfr_addr_in == adc_fmt_pkg::RES_LO_ADDR;
   wire               gain_en   = cfg_q[adc_fmt_pkg::CFG_GAIN_EN_BIT];
   wire               ljst      = ctl_q[adc_fmt_pkg::CTL_LJST_BIT];
   wire               gaddr_wr  = hi_wr && gain_en;
   wire               gdata_wr  = lo_wr && gain_en;
   wire               res_hi_wr = hi_wr && !gain_en;
   wire               res_lo_wr = lo_wr && !gain_en;
   wire adc_fmt_pkg::rpt_e rpt  = adc_fmt_pkg::rpt_e'(cfg_q[adc_fmt_pkg::CFG_RPT_LSB +: 2]);
   wire               up_sel    = gain_addr_q == adc_fmt_pkg::GAIN_UPPER_ADDR;
   wire               lo_sel    = gain_addr_q == adc_fmt_pkg::GAIN_LOWER_ADDR;
   wire               ex_sel    = gain_addr_q == adc_fmt_pkg::GAIN_EXTRA_ADDR;

   acc_if acc ();

   assign acc.conv_done = conv_done_in;
   assign acc.sample    = sample_in;
   assign acc.rpt       = rpt;
   assign acc.restart   = cfg_wr;

   sample_accumulator i_sample_accumulator (
      .clk_in   (mclk_in),
      .rst_n_in (rst_n_q),
      .acc      (acc)
   );

   // ---------------------------------------------------------------
   // Result formatting
   // ---------------------------------------------------------------
   function automatic logic [15:0] format_result(input logic [15:0] sum,
                                                 input adc_fmt_pkg::rpt_e r,
                                                 input logic lj);
      logic [15:0] f;
      f = sum;
      if (r == adc_fmt_pkg::RPT_1)
         f = lj ? {sum[11:0], 4'h0} : {4'h0, sum[11:0]};
      return f;
   endfunction

   wire [15:0] formatted = format_result(acc.sum, rpt, ljst);

   always_comb
   begin
      result_d = result_q;
      if (res_hi_wr)
         result_d[15:8] = sfr_wdata_in;
      if (res_lo_wr)
         result_d[7:0] = sfr_wdata_in;
      if (acc.sum_valid)
         result_d = formatted;
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge mclk_in or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         cfg_q    <= adc_fmt_pkg::CFG_RESET;
         ctl_q    <= adc_fmt_pkg::CTL_RESET;
         result_q <= adc_fmt_pkg::RES_RESET;
         update_q <= 1'b0;
      end
      else
      begin
         if (cfg_wr)
            cfg_q <= sfr_wdata_in;
         if (ctl_wr)
            ctl_q <= sfr_wdata_in;
         result_q <= result_d;
         update_q <= acc.sum_valid;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         gain_addr_q  <= adc_fmt_pkg::GAIN_ADDR_RESET;
         gain_upper_q <= adc_fmt_pkg::GAIN_UPPER_RESET;
         gain_lower_q <= adc_fmt_pkg::GAIN_LOWER_RESET;
         gain_extra_q <= adc_fmt_pkg::GAIN_EXTRA_RESET;
      end
      else
      begin
         if (gaddr_wr)
            gain_addr_q <= sfr_wdata_in;
         if (gdata_wr && up_sel)
            gain_upper_q <= sfr_wdata_in;
         if (gdata_wr && lo_sel)
            gain_lower_q <= sfr_wdata_in[adc_fmt_pkg::GAIN_LOWER_LSB +: 4];
         if (gdata_wr && ex_sel)
            gain_extra_q <= sfr_wdata_in[adc_fmt_pkg::GAIN_EXTRA_BIT];
      end
   end

   // Read path: gain registers deliberately absent
   always_ff @(posedge mclk_in or negedge rst_n_q)
   begin
      if (!rst_n_q)
         rdata_q <= 8'h00;
      else
         unique case (sfr_addr_in)
            adc_fmt_pkg::CFG_ADDR:    rdata_q <= cfg_q;
            adc_fmt_pkg::CTL_ADDR:    rdata_q <= ctl_q;
            adc_fmt_pkg::RES_HI_ADDR: rdata_q <= result_q[15:8];
            adc_fmt_pkg::RES_LO_ADDR: rdata_q <= result_q[7:0];
            default:                  rdata_q <= 8'h00;
         endcase
   end

   assign sfr_rdata_out     = rdata_q;
   assign result_update_out = update_q;
   assign gain_word_out     = {gain_upper_q, gain_lower_q};
   assign gain_extra_out    = gain_extra_q;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_q);

   sequence s_single_done;
      conv_done_in && !cfg_wr && rpt == adc_fmt_pkg::RPT_1;
   endsequence

   sequence s_upper_addr;
      gaddr_wr && sfr_wdata_in == adc_fmt_pkg::GAIN_UPPER_ADDR;
   endsequence

   // Data write straight after the address, or two cycles later with no gain address write in between
   sequence s_upper_data;
      (s_upper_addr ##1 gdata_wr) or (s_upper_addr ##1 !gaddr_wr ##1 gdata_wr);
   endsequence

   a_single_refresh: assert property (
      s_single_done |-> ##1 acc.sum_valid ##1 update_q)
      else $error("single conversion did not refresh the result");
   a_right_zero_top: assert property (
      acc.sum_valid && rpt == adc_fmt_pkg::RPT_1 && !ljst
      |=> result_q == {4'h0, $past(acc.sum[11:0])})
      else $error("right-justified result wrong");
   a_left_zero_low: assert property (
      acc.sum_valid && rpt == adc_fmt_pkg::RPT_1 && ljst
      |=> result_q == {$past(acc.sum[11:0]), 4'h0})
      else $error("left-justified result wrong");
   a_accum_hidden: assert property (
      !acc.sum_valid && !res_hi_wr && !res_lo_wr |=> $stable(result_q))
      else $error("result changed mid series");
   a_rpt4_width: assert property (
      acc.sum_valid && rpt == adc_fmt_pkg::RPT_4 |=> result_q[15:14] == 2'b00)
      else $error("four-sample sum too wide");
   a_gain_upper_prog: assert property (
      s_upper_data |=> gain_upper_q == $past(sfr_wdata_in))
      else $error("gain upper byte not stored");
   a_gain_bad_addr: assert property (
      gdata_wr && !up_sel && !lo_sel && !ex_sel
      |=> $stable(gain_upper_q) && $stable(gain_lower_q) && $stable(gain_extra_q))
      else $error("gain changed on unknown address");
   a_gain_no_read: assert property (
      sfr_addr_in == adc_fmt_pkg::GAIN_UPPER_ADDR |=> sfr_rdata_out == 8'h00)
      else $error("gain register visible on read");
   a_result_write_gated: assert property (
      gain_en && !acc.sum_valid |=> $stable(result_q))
      else $error("result written during gain access");

endmodule

// *** adc_fmt_pkg.sv ***
package adc_fmt_pkg;

   // ---------------------------------------------------------------
   // Register port addresses
   // ---------------------------------------------------------------
   localparam logic [7:0]  CFG_ADDR          = 8'hbc;
   localparam logic [7:0]  RES_LO_ADDR       = 8'hbd;
   localparam logic [7:0]  RES_HI_ADDR       = 8'hbe;
   localparam logic [7:0]  CTL_ADDR          = 8'he8;

   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int          CFG_GAIN_EN_BIT   = 0;
   localparam int          CFG_RPT_LSB       = 1;
   localparam int          CTL_LJST_BIT      = 2;
   localparam int          GAIN_LOWER_LSB    = 4;
   localparam int          GAIN_EXTRA_BIT    = 0;
   localparam logic [7:0]  CFG_RESET         = 8'hf8;
   localparam logic [7:0]  CTL_RESET         = 8'h00;
   localparam logic [15:0] RES_RESET         = 16'h0000;

   // ---------------------------------------------------------------
   // Indirect gain addresses and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0]  GAIN_UPPER_ADDR   = 8'h04;
   localparam logic [7:0]  GAIN_LOWER_ADDR   = 8'h07;
   localparam logic [7:0]  GAIN_EXTRA_ADDR   = 8'h08;
   localparam logic [7:0]  GAIN_UPPER_RESET  = 8'hfc;
   localparam logic [3:0]  GAIN_LOWER_RESET  = 4'h0;
   localparam logic        GAIN_EXTRA_RESET  = 1'b1;
   localparam logic [7:0]  GAIN_ADDR_RESET   = 8'h00;

   typedef enum logic [1:0] {RPT_1, RPT_4, RPT_8, RPT_16} rpt_e;

   function automatic logic [4:0] rpt_samples(input rpt_e r);
      logic [4:0] n;
      n = 5'h01;
      unique case (r)
         RPT_1:  n = 5'h01;
         RPT_4:  n = 5'h04;
         RPT_8:  n = 5'h08;
         RPT_16: n = 5'h10;
      endcase
      return n;
   endfunction

endpackage

// *** acc_if.sv ***
interface acc_if;
   logic                conv_done;
   logic [11:0]         sample;
   adc_fmt_pkg::rpt_e   rpt;
   logic                restart;
   logic [15:0]         sum;
   logic                sum_valid;

   modport acc (input conv_done, input sample, input rpt, input restart,
                output sum, output sum_valid);
   modport ctl (output conv_done, output sample, output rpt, output restart,
                input sum, input sum_valid);
endinterface

// *** sample_accumulator.sv ***
module sample_accumulator (
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   acc_if.acc        acc
);

   logic [4:0]  count_q;
   logic [15:0] run_sum_q;
   logic [15:0] sum_q;
   logic        valid_q;

   wire  [4:0]  target    = adc_fmt_pkg::rpt_samples(acc.rpt);
   wire         last      = (count_q + 5'h01) == target;
   wire  [15:0] next_sum  = run_sum_q + {4'h0, acc.sample};

   assign acc.sum       = sum_q;
   assign acc.sum_valid = valid_q;

   // ---------------------------------------------------------------
   // Running sum, visible only after the final sample
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         count_q   <= 5'h00;
         run_sum_q <= 16'h0000;
         sum_q     <= 16'h0000;
         valid_q   <= 1'b0;
      end
      else if (acc.restart)
      begin
         count_q   <= 5'h00;
         run_sum_q <= 16'h0000;
         valid_q   <= 1'b0;
      end
      else if (acc.conv_done && last)
      begin
         sum_q     <= next_sum;
         valid_q   <= 1'b1;
         count_q   <= 5'h00;
         run_sum_q <= 16'h0000;
      end
      else if (acc.conv_done)
      begin
         count_q   <= count_q + 5'h01;
         run_sum_q <= next_sum;
         valid_q   <= 1'b0;
      end
      else
      begin
         valid_q   <= 1'b0;
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   a_series_end_sum: assert property (
      acc.conv_done && !acc.restart && last |=> valid_q && sum_q == $past(next_sum))
      else $error("series end did not publish the sum");
   a_series_mid_quiet: assert property (
      acc.conv_done && !acc.restart && !last |=> !valid_q)
      else $error("sum published before the last sample");
   a_count_bound: assert property (
      count_q < target || acc.restart || $changed(acc.rpt))
      else $error("sample count passed the repeat count");

endmodule

// *** adc_result_format_tb_top.sv ***
module adc_result_format_tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   logic        mclk;
   logic        arst_n;
   logic [7:0]  sfr_addr;
   logic [7:0]  sfr_wdata;
   logic        sfr_wr;
   logic [7:0]  sfr_rdata;
   logic        conv_done;
   logic [11:0] sample;
   logic        result_update;
   logic [11:0] gain_word;
   logic        gain_extra;
   int          err_count;
   int          tests_run;
   logic [15:0] res;
   logic [7:0]  rb;

   adc_result_format i_adc_result_format (
      .mclk_in           (mclk),
      .arst_n_in         (arst_n),
      .sfr_addr_in       (sfr_addr),
      .sfr_wdata_in      (sfr_wdata),
      .sfr_wr_in         (sfr_wr),
      .sfr_rdata_out     (sfr_rdata),
      .conv_done_in      (conv_done),
      .sample_in         (sample),
      .result_update_out (result_update),
      .gain_word_out     (gain_word),
      .gain_extra_out    (gain_extra)
   );

   always #25 mclk = ~mclk;

   // ---------------------------------------------------------------
   // Bus and check tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      #2;
      sfr_addr  = a;
      sfr_wdata = d;
      sfr_wr    = 1'b1;
      @(posedge mclk);
      #2;
      sfr_wr    = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      #2;
      sfr_addr = a;
      @(posedge mclk);
      #1;
      d = sfr_rdata;
   endtask

   task automatic rd_res(output logic [15:0] r);
      logic [7:0] lo;
      logic [7:0] hi;
      rd(adc_fmt_pkg::RES_LO_ADDR, lo);
      rd(adc_fmt_pkg::RES_HI_ADDR, hi);
      r = {hi, lo};
   endtask

   task automatic conv(input logic [11:0] s);
      @(posedge mclk);
      #2;
      conv_done = 1'b1;
      sample    = s;
      @(posedge mclk);
      #2;
      conv_done = 1'b0;
      sample    = ~s;
   endtask

   task automatic settle();
      repeat (3) @(posedge mclk);
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      chk({4'h0, gain_word}, 16'h0fc0);
      chk({15'h0, gain_extra}, 16'h0001);
      rd(adc_fmt_pkg::CFG_ADDR, rb);
      chk({8'h00, rb}, 16'h00f8);
      rd_res(res);
      chk(res, 16'h0000);
   endtask

   task automatic t_single();
      wr(adc_fmt_pkg::CFG_ADDR, 8'hf8);
      wr(adc_fmt_pkg::CTL_ADDR, 8'h00);
      conv(12'hfff);
      chk({15'h0, result_update}, 16'h0000);
      @(posedge mclk);
      #1;
      chk({15'h0, result_update}, 16'h0001);
      @(posedge mclk);
      #1;
      chk({15'h0, result_update}, 16'h0000);
      settle();
      rd_res(res);
      chk(res, 16'h0fff);
      conv(12'h7ff);
      settle();
      rd_res(res);
      chk(res, 16'h07ff);
      wr(adc_fmt_pkg::CTL_ADDR, 8'h04);
      conv(12'h800);
      settle();
      rd_res(res);
      chk(res, 16'h8000);
      conv(12'hfff);
      settle();
      rd_res(res);
      chk(res, 16'hfff0);
      wr(adc_fmt_pkg::CTL_ADDR, 8'h00);
   endtask

   task automatic t_accum();
      logic [15:0] exp [3] = '{16'h3ffc, 16'h7ff8, 16'hfff0};
      int          n;
      for (int r = 1; r < 4; r++)
      begin
         wr(adc_fmt_pkg::CFG_ADDR, 8'hf8 | 8'(r << 1));
         n = 2 << r;
         for (int i = 0; i < n; i++)
            conv(12'hfff);
         settle();
         rd_res(res);
         chk(res, exp[r-1]);
      end
      wr(adc_fmt_pkg::CFG_ADDR, 8'hfa);
      for (int i = 1; i < 4; i++)
         conv(12'(i));
      settle();
      rd_res(res);
      chk(res, 16'hfff0);
      conv(12'h004);
      settle();
      rd_res(res);
      chk(res, 16'h000a);
   endtask

   task automatic t_gain();
      wr(adc_fmt_pkg::CFG_ADDR, 8'hf9);
      wr(adc_fmt_pkg::RES_HI_ADDR, 8'h04);
      wr(adc_fmt_pkg::RES_LO_ADDR, 8'h6c);
      wr(adc_fmt_pkg::RES_HI_ADDR, 8'h07);
      wr(adc_fmt_pkg::RES_LO_ADDR, 8'ha5);
      wr(adc_fmt_pkg::RES_HI_ADDR, 8'h08);
      wr(adc_fmt_pkg::RES_LO_ADDR, 8'hfe);
      @(posedge mclk);
      #1;
      chk({4'h0, gain_word}, 16'h06ca);
      chk({15'h0, gain_extra}, 16'h0000);
      wr(adc_fmt_pkg::RES_HI_ADDR, 8'h05);
      wr(adc_fmt_pkg::RES_LO_ADDR, 8'hff);
      @(posedge mclk);
      #1;
      chk({3'h0, gain_extra, gain_word}, 16'h06ca);
      wr(adc_fmt_pkg::RES_HI_ADDR, 8'h08);
      wr(adc_fmt_pkg::RES_LO_ADDR, 8'h01);
      wr(adc_fmt_pkg::CFG_ADDR, 8'hf8);
      @(posedge mclk);
      #1;
      chk({15'h0, gain_extra}, 16'h0001);
      rd_res(res);
      chk(res, 16'h000a);
      wr(adc_fmt_pkg::RES_LO_ADDR, 8'h5a);
      rd_res(res);
      chk(res, 16'h005a);
      rd(adc_fmt_pkg::GAIN_UPPER_ADDR, rb);
      chk({8'h00, rb}, 16'h0000);
      rd(adc_fmt_pkg::GAIN_LOWER_ADDR, rb);
      chk({8'h00, rb}, 16'h0000);
      rd(adc_fmt_pkg::GAIN_EXTRA_ADDR, rb);
      chk({8'h00, rb}, 16'h0000);
   endtask

   // ---------------------------------------------------------------
   // Run control
   // ---------------------------------------------------------------
   task automatic end_sim();
      $display("checks=%0d mismatches=%0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial
   begin
      #100000;
      err_count++;
      end_sim();
   end

   initial
   begin
      mclk      = 1'b0;
      arst_n    = 1'b0;
      sfr_addr  = 8'h00;
      sfr_wdata = 8'h00;
      sfr_wr    = 1'b0;
      conv_done = 1'b0;
      sample    = 12'h000;
      err_count = 0;
      tests_run = 0;
      repeat (5) @(posedge mclk);
      #2;
      arst_n = 1'b1;
      repeat (3) @(posedge mclk);
      t_reset();
      t_single();
      t_accum();
      t_gain();
      end_sim();
   end
endmodule
